/* File: saclk_pkg.sv */
// Constants, field layout and carrier types for the serial audio clock and format block.
package saclk_pkg;

  // Register byte addresses
  localparam logic [31:0] SACLK_CTRL_ADDR = 32'hfff09028;
  localparam logic [31:0] SACLK_STAT_ADDR = 32'hfff090f0;
  localparam logic [31:0] SACLK_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] SACLK_CTRL_WMASK = 32'h000f00f8;

  // Field positions in the control register
  localparam int SACLK_DIV_LSB = 16;
  localparam int SACLK_BSEL_LSB = 6;
  localparam int SACLK_FS_BIT = 5;
  localparam int SACLK_MSEL_BIT = 4;
  localparam int SACLK_FMT_BIT = 3;

  // Field positions in the status register
  localparam int SACLK_ST_DIV_LSB = 8;
  localparam int SACLK_ST_POS_LSB = 16;

  // Bit clock select codes
  localparam logic [1:0] SACLK_BSEL_32 = 2'h0;
  localparam logic [1:0] SACLK_BSEL_48 = 2'h1;

  // Master clocks per bit clock, minus one
  localparam logic [3:0] SACLK_BRATIO_8_M1 = 4'h7;
  localparam logic [3:0] SACLK_BRATIO_12_M1 = 4'hb;

  // Bit clocks per sample, minus one
  localparam logic [5:0] SACLK_BITS_32_M1 = 6'h1f;
  localparam logic [5:0] SACLK_BITS_48_M1 = 6'h2f;

  // Divisor codes with a special meaning
  localparam logic [3:0] SACLK_DIV_CODE_10 = 4'h9;
  localparam logic [3:0] SACLK_DIV_CODE_14 = 4'he;
  localparam logic [3:0] SACLK_DIV_CODE_16 = 4'hf;
  localparam logic [3:0] SACLK_DIV_CODE_MAX8 = 4'h7;

  // Programmed configuration carried as one word
  typedef struct packed {
    logic [3:0] div_code; // master_clock_divide_code
    logic [1:0] bclk_sel; // bit clock select
    logic rate_sel; // sample_rate_ratio_select
    logic mclk_sel; // master clock source
    logic msb_just; // framing format
  } saclk_cfg_s;

endpackage

/* File: saclk_ctrl.sv */
// Serial audio clock generator and format control with a classic Wishbone register slave.
//
// The implementer's own choice: the Wishbone interface to the registers.
module saclk_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic mclk_o,
  output logic bclk_o,
  output logic lrclk_o,
  output logic slot_start_o,
  output logic msb_just_o
);

  // Divisor minus one for a code; reserved codes fall back to divide-by-1
  function automatic logic [3:0] div_m1(input logic [3:0] code);
    logic [3:0] r;
    r = 4'h0;
    if (code <= saclk_pkg::SACLK_DIV_CODE_MAX8) begin
      r = code;
    end else if (code == saclk_pkg::SACLK_DIV_CODE_10) begin
      r = 4'h9;
    end else if (code == saclk_pkg::SACLK_DIV_CODE_14) begin
      r = 4'hd;
    end else if (code == saclk_pkg::SACLK_DIV_CODE_16) begin
      r = 4'hf;
    end
    return r;
  endfunction

  logic [31:0] ctrl_r; // Control register image
  saclk_pkg::saclk_cfg_s cfg; // Decoded fields
  logic [31:0] ctrl_nxt; // Control after a write
  logic ack_r; // Wishbone acknowledge
  logic [31:0] rdat_r; // Read data register
  logic req; // New access this cycle
  logic hit_ctrl; // Control register selected
  logic hit_stat; // Status register selected
  logic [31:0] stat; // Status word
  logic [3:0] dm1; // Current divisor minus one
  logic bypass; // Input clock passes through
  logic odd_div; // Divisor is 1, 3, 5 or 7
  logic [3:0] pre_cnt_r; // Prescaler phase
  logic mclk_tick; // Master clock rising event
  logic [3:0] bratio_m1; // Master clocks per bit clock, minus one
  logic [3:0] bcnt_r; // Bit clock phase
  logic bclk_r; // Bit clock level
  logic bclk_fall; // Bit clock falling event
  logic [5:0] bits_m1; // Bit clocks per sample, minus one
  logic [5:0] pos_r; // Bit slot within the sample
  logic [5:0] pos_nxt; // Next bit slot
  logic [5:0] half; // First slot of the right channel
  logic lrclk_r; // Word select level
  logic slot_r; // Channel start pulse

  // Field extraction from the control image
  assign cfg.div_code = ctrl_r[saclk_pkg::SACLK_DIV_LSB +: 4];
  assign cfg.bclk_sel = ctrl_r[saclk_pkg::SACLK_BSEL_LSB +: 2];
  assign cfg.rate_sel = ctrl_r[saclk_pkg::SACLK_FS_BIT];
  assign cfg.mclk_sel = ctrl_r[saclk_pkg::SACLK_MSEL_BIT];
  assign cfg.msb_just = ctrl_r[saclk_pkg::SACLK_FMT_BIT];

  // Address decode, word address compare on bits 31:2, byte offset ignored
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign hit_ctrl = (wb_adr_i[31:2] == saclk_pkg::SACLK_CTRL_ADDR[31:2]);
  assign hit_stat = (wb_adr_i[31:2] == saclk_pkg::SACLK_STAT_ADDR[31:2]);

  // Byte-lane merge; reserved bits never stick
  always_comb begin
    ctrl_nxt = ctrl_r;
    for (int i = 0; i < 4; i++) begin
      if (wb_sel_i[i]) begin
        ctrl_nxt[i*8 +: 8] = wb_dat_i[i*8 +: 8];
      end
    end
    ctrl_nxt = ctrl_nxt & saclk_pkg::SACLK_CTRL_WMASK;
  end

  // Live clock state for software; unused bits read zero
  always_comb begin
    stat = 32'h00000000;
    stat[0] = bclk_r; // Bit clock level
    stat[1] = lrclk_r; // Word select level
    stat[2] = slot_r; // Channel start pulse
    stat[saclk_pkg::SACLK_ST_DIV_LSB +: 4] = dm1; // Divisor minus one
    stat[saclk_pkg::SACLK_ST_POS_LSB +: 6] = pos_r; // Bit slot
  end

  // Control register write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= saclk_pkg::SACLK_CTRL_RESET;
    end else if (ce_i && req && wb_we_i && hit_ctrl) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // One-cycle acknowledge; unmapped addresses ack and read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end else if (ce_i) begin
      ack_r <= req;
      if (req && !wb_we_i) begin
        if (hit_ctrl) begin
          rdat_r <= ctrl_r;
        end else if (hit_stat) begin
          rdat_r <= stat;
        end else begin
          rdat_r <= 32'h00000000;
        end
      end
    end
  end

  // Bus outputs come straight from flops
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // Prescaler selection
  assign dm1 = div_m1(cfg.div_code);
  assign bypass = cfg.mclk_sel || (dm1 == 4'h0);
  assign odd_div = !dm1[0]; // Even m1 means odd divisor

  // Prescaler counter, wraps safely if the divisor shrinks mid-count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt_r <= 4'h0;
    end else if (ce_i) begin
      if (bypass || pre_cnt_r >= dm1) begin
        pre_cnt_r <= 4'h0;
      end else begin
        pre_cnt_r <= pre_cnt_r + 4'h1;
      end
    end
  end

  assign mclk_tick = ce_i && (bypass || pre_cnt_r == 4'h0);

  // Master clock out; odd divisors are high for half an input period only.
  // The low phase is gated, so the count changes only while the gate is shut:
  // gating the high phase would leak a runt pulse as the count leaves zero.
  always_comb begin
    if (bypass) begin
      mclk_o = clk_i;
    end else if (odd_div) begin
      mclk_o = !clk_i && (pre_cnt_r == 4'h0);
    end else begin
      mclk_o = (pre_cnt_r <= (dm1 >> 1));
    end
  end

  // Bit clock ratio and sample length; codes 10 and 11 act as 00
  always_comb begin
    if (cfg.bclk_sel == saclk_pkg::SACLK_BSEL_48) begin
      bratio_m1 = saclk_pkg::SACLK_BRATIO_8_M1;
      bits_m1 = saclk_pkg::SACLK_BITS_48_M1;
    end else begin
      bratio_m1 = cfg.rate_sel ? saclk_pkg::SACLK_BRATIO_12_M1
                             : saclk_pkg::SACLK_BRATIO_8_M1;
      bits_m1 = saclk_pkg::SACLK_BITS_32_M1;
    end
  end

  // Falls midway through the bit clock period
  assign bclk_fall = mclk_tick && (bcnt_r == (bratio_m1 >> 1));

  // Bit clock divider, counting master clock edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bcnt_r <= 4'h0;
      bclk_r <= 1'b0;
    end else if (mclk_tick) begin
      if (bcnt_r >= bratio_m1) begin
        bcnt_r <= 4'h0;
        bclk_r <= 1'b1;
      end else begin
        bcnt_r <= bcnt_r + 4'h1;
        if (bclk_fall) begin
          bclk_r <= 1'b0;
        end
      end
    end
  end

  // Slot position after the next falling bit clock edge
  assign pos_nxt = (pos_r >= bits_m1) ? 6'h00 : pos_r + 6'h01;
  assign half = (bits_m1 >> 1) + 6'h01;

  // Word select and channel start, both moved on falling bit clock edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_r <= 6'h00;
      lrclk_r <= 1'b0;
      slot_r <= 1'b0;
    end else if (ce_i) begin
      slot_r <= 1'b0;
      if (bclk_fall) begin
        pos_r <= pos_nxt;
        slot_r <= (pos_nxt == 6'h00) || (pos_nxt == half);
        if (cfg.msb_just) begin
          lrclk_r <= (pos_nxt >= half);
        end else begin
          lrclk_r <= ((pos_nxt >= bits_m1 ? 6'h00 : pos_nxt + 6'h01) >= half);
        end
      end
    end
  end

  // Serial clock outputs straight from flops
  assign bclk_o = bclk_r;
  assign lrclk_o = lrclk_r;
  assign slot_start_o = slot_r;
  assign msb_just_o = cfg.msb_just;

endmodule

/* File: saclk_sva.sv */
// Checker for bus handshake and serial clock framing.
module saclk_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic bclk_o,
  input wire logic lrclk_o,
  input wire logic slot_start_o,
  input wire logic msb_just_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken by the slave
  sequence taken_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  // Taken request aimed at the control word
  sequence ctl_s;
    taken_s ##0 wb_adr_i == 32'hfff09028;
  endsequence
  chk_ack_next: assert property (taken_s |=> wb_ack_o) else $error("ack late");
  chk_ack_once: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack long");
  chk_fmt_write: assert property (ctl_s ##0 wb_we_i && wb_sel_i[0] |=>
    msb_just_o == $past(wb_dat_i[3])) else $error("format bit");
  // Reserved bits must read back as zero
  chk_ctrl_rsvd: assert property (ctl_s ##0 !wb_we_i |=>
    (wb_dat_o & 32'hfff0ff07) == 32'h0) else $error("reserved bits");
  chk_slot_once: assert property (slot_start_o && ce_i |=> !slot_start_o) else $error("slot");
  chk_slot_low: assert property (slot_start_o |-> !bclk_o) else $error("slot edge");
  chk_lr_low: assert property ($changed(lrclk_o) |-> !bclk_o) else $error("word edge");
  chk_bclk_hold: assert property ($rose(bclk_o) |=> bclk_o) else $error("bit clock");
endmodule
bind saclk_ctrl saclk_sva u_saclk_sva (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .bclk_o(bclk_o), .lrclk_o(lrclk_o), .slot_start_o(slot_start_o), .msb_just_o(msb_just_o));

/* File: saclk_codec.sv */
// Codec stand-in that times the serial clocks it receives.
module saclk_codec (
  input wire logic clk_i,
  input wire logic mclk_i,
  input wire logic bclk_i,
  input wire logic lrclk_i,
  output int per_o,
  output int mper_o,
  output int bits_o,
  output int hi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int c, m, b;
  realtime t;
  logic bq, lq, bm;
  // Cycles per bit clock and bit clocks per frame
  always @(posedge clk_i) begin
    bq <= bclk_i;
    lq <= lrclk_i;
    c <= c + 1;
    if (bclk_i && !bq) begin
      per_o <= c;
      c <= 1;
      b <= b + 1;
    end
    if (lrclk_i && !lq) begin
      bits_o <= b;
      b <= 0;
    end
  end
  // Master clocks per bit clock
  always @(posedge mclk_i) begin
    bm <= bclk_i;
    m <= m + 1;
    t = $realtime;
    if (bclk_i && !bm) begin
      mper_o <= m;
      m <= 1;
    end
  end
  // High time of the master clock in ns
  always @(negedge mclk_i) hi_o <= int'($realtime - t);
endmodule

/* File: tb_top.sv */
// Self-checking bench for the serial audio clock and format block.
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
  $display("BAD %0t got %0h want %0h", $time, a, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CTRL = 32'hfff09028; // Control word
  localparam logic [31:0] HOLE = 32'hfff09100; // Unmapped place
  localparam logic [31:0] STAT = 32'hfff090f0; // Status word
  logic clk_i = 0, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0;
  logic [31:0] adr = 0, wdat = 0, rdat, q, d;
  logic [3:0] sel = 0;
  logic ack, mclk, bclk, lrclk, fmt, slot;
  logic [1:0] frz;
  int err_count, n_compared, cyc_n, per, mper, bits, hi, dv, r, code, bs, fs, ms, f;
  int ns, ns0, dc;
  int codes[6] = '{0, 2, 9, 14, 15, 5};
  always #4 clk_i = ~clk_i;
  saclk_ctrl u_saclk_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .mclk_o(mclk), .bclk_o(bclk), .lrclk_o(lrclk),
    .slot_start_o(slot), .msb_just_o(fmt));
  // Channel start pulses counted for the framing check
  always @(posedge clk_i) begin
    if (slot === 1'b1) ns <= ns + 1;
  end
  saclk_codec u_saclk_codec (.clk_i(clk_i), .mclk_i(mclk), .bclk_i(bclk), .lrclk_i(lrclk),
    .per_o(per), .mper_o(mper), .bits_o(bits), .hi_o(hi));
  task automatic tally_and_finish();
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One classic cycle, held until ack is seen
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] v);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= v; sel <= 4'hf;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 0; stb <= 0;
    @(posedge clk_i);
  endtask
  // Cut a hang short
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 100000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(58612));
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    wb(0, CTRL, 0);
    `CHK(q, 32'h0)
    wb(1, HOLE, '1);
    wb(0, HOLE, 0);
    `CHK(q, 32'h0)
    for (int i = 0; i < 6; i++) begin
      code = (i == 5) ? $urandom_range(7) : codes[i];
      fs = i % 2;
      bs = (i == 3);
      ms = (i == 5);
      f = $urandom_range(1);
      d = ($urandom & 32'hfff0ff07) | code << 16 | bs << 6 | fs << 5 | ms << 4 | f << 3;
      wb(1, CTRL, d);
      `CHK(fmt, f[0])
      wb(0, CTRL, 0);
      `CHK(q, d & 32'h000f00f8)
      r = (fs && !bs) ? 12 : 8;
      dc = code < 8 ? code + 1 : code == 9 ? 10 : code == 14 ? 14 : 16;
      dv = ms ? 1 : dc;
      repeat (2) @(posedge lrclk);
      ns0 = ns;
      @(posedge lrclk);
      `CHK(ns - ns0, 2)
      repeat (2) @(posedge clk_i);
      `CHK(mper, r)
      `CHK(per, dv * r)
      `CHK(bits, bs ? 48 : 32)
      `CHK(mper * bits, fs ? 384 : 256)
      `CHK(hi, dv % 2 ? 4 : dv * 4)
      wb(0, STAT, 0);
      `CHK(q[11:8], dc - 1)
      ce_i <= 0;
      @(posedge clk_i);
      frz[1] = bclk;
      frz[0] = lrclk;
      repeat (20) @(posedge clk_i);
      `CHK(bclk, frz[1])
      `CHK(lrclk, frz[0])
      ce_i <= 1;
    end
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    `CHK(bclk, 1'b0)
    `CHK(lrclk, 1'b0)
    `CHK(fmt, 1'b0)
    wb(0, CTRL, 0);
    `CHK(q, 32'h0)
    tally_and_finish();
  end
endmodule
